// [wts_pkg.sv]
// package: constants, codes and types of the wait/trigger/step sequencer
package wts_pkg;
  // apb register byte offsets
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] HOLD_OFS      = 8'h04;
  localparam logic [7:0] SETTLE_OFS    = 8'h08;
  localparam logic [7:0] STATUS_OFS    = 8'h0c;
  localparam logic [7:0] SCAN_OFS      = 8'h10;
  localparam logic [7:0] CMD_OFS       = 8'h14;
  localparam logic [7:0] TRIGCNT_OFS   = 8'h18;
  // command codes written to CMD
  localparam logic [2:0] CMD_HOLD      = 3'h1;
  localparam logic [2:0] CMD_TRIG_WAIT = 3'h2;
  localparam logic [2:0] CMD_SAMPLE    = 3'h3;
  localparam logic [2:0] CMD_QUERY     = 3'h4;
  localparam logic [2:0] CMD_SCAN_RUN  = 3'h5;
  localparam logic [2:0] CMD_CNT_RST   = 3'h6;
  // ctrl field positions
  localparam int CTRL_POLICY_BIT  = 0;
  localparam int CTRL_COUPLED_BIT = 1;
  localparam int CTRL_MACROQ_BIT  = 2;
  // reset values and limits
  localparam logic       POLICY_RST   = 1'b0;     // 0 = buffer
  localparam logic [31:0] SETTLE_RST  = 32'h0000_0000;
  localparam logic [31:0] HOLD_MAX    = 32'h3b9a_c9f6; // 999,999,990 tenths
  localparam logic [7:0] TRIG_FULL    = 8'hff;    // 255 pulses
  // tick prescaler
  localparam longint CLK_HZ     = 25_000_000;
  localparam longint TICK_MS    = 100;
  localparam logic [21:0] TICK_CYCLES =
    22'(CLK_HZ * TICK_MS / 1000);
  localparam int CMDQ_DEPTH = 4;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_HOLD   = 3'b001,
    ST_SETTLE = 3'b010,
    ST_TWAIT  = 3'b011,
    ST_SCAN   = 3'b100
  } wts_state_t;
endpackage

// [wts_sequencer.sv]
// module: command sequencer with hold, settle, trigger and step handling
//
// Contract
// - hold up to 99,999,999 s, then resume
// - hold counted in tenths of a second
// - only expiry or device-clear ends a hold
// - commands during hold queued, run after
// - hold indicator with remaining, unless macro query
// - no echo or prompt during hold; echo at expiry
// - new query aborts pending earlier query
// - settle delay on every sample selection
// - one settle delay shared by all inputs
// - device-clear aborts a settling sample selection
// - trigger policy buffer or error, buffer default
// - policy write empties trigger buffer
// - buffer counts up to 255 pulses
// - error policy latches flag, shown with result
// - no unexpected flag under buffer policy
// - trigger wait stalls until pulse consumed
// - step advances waiting root, else nothing
// - step advances params, measures, increments count
// - step stops continuous scan, keeps params
// - no coupled params gives error, no action
// - counter at nonzero limit gives only error
`timescale 1ns/100ps
module wts_sequencer
  import wts_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // external events
  input  wire logic        trig_in,
  input  wire logic        step_key,
  input  wire logic        dev_clear,
  input  wire logic        meas_done,
  // engine and display side
  output logic             meas_start,
  output logic             scan_advance,
  output logic             query_abort,
  output logic             hold_indicator_text,
  output logic             echo_enable,
  output logic             prompt_enable,
  output logic             err_unexp_trig,
  output logic             err_no_couple,
  output logic             err_count_reached
);
  wts_state_t state;
  logic [21:0] presc;
  logic        tick;
  logic [31:0] hold_left;
  logic [31:0] sample_settle_time;
  logic        trigger_policy;
  logic        coupled;
  logic        macro_query;
  logic [31:0] hold_len;
  logic        scan_cont;
  logic [7:0]  trig_cnt;
  logic        unexp_trig;
  logic [15:0] scan_iteration_count;
  logic [15:0] scan_iteration_limit;
  logic        query_pending;
  logic [2:0]  cmdq [CMDQ_DEPTH];
  logic [2:0]  q_wr, q_rd;
  logic [31:0] q_arg [CMDQ_DEPTH];
  logic        q_empty, q_full;
  logic        wr_acc, rd_acc, cmd_wr, policy_wr, trig_take;
  logic        buf_take;
  logic        step_ok, cnt_hit;
  logic [2:0]  cur_cmd;
  logic [31:0] cur_arg;
  logic [31:0] next_rdata;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  assign wr_acc    = psel && penable && pwrite;
  assign rd_acc    = psel && !penable && !pwrite;
  assign cmd_wr    = wr_acc && hit(paddr, CMD_OFS) && !q_full;
  assign policy_wr = wr_acc && hit(paddr, CTRL_OFS);
  assign q_empty   = q_wr == q_rd;
  assign q_full    = (q_wr[1:0] == q_rd[1:0]) && (q_wr[2] != q_rd[2]);
  assign cur_cmd   = cmdq[q_rd[1:0]];
  assign cur_arg   = q_arg[q_rd[1:0]];
  assign cnt_hit   = (scan_iteration_limit != 16'h0000) &&
                     (scan_iteration_count >= scan_iteration_limit);
  assign step_ok   = step_key && coupled && !cnt_hit &&
                     (state == ST_IDLE || state == ST_SCAN);
  // only a trigger wait takes pulses: a live one or the oldest buffered
  assign buf_take  = state == ST_TWAIT && trig_cnt != 8'h00;
  assign trig_take = state == ST_TWAIT && (trig_in || buf_take);

  // prescaler: one tick every tenth of a second
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      presc <= 22'h00_0000;
      tick  <= 1'b0;
    end else if (presc == TICK_CYCLES - 22'h00_0001) begin
      presc <= 22'h00_0000;
      tick  <= 1'b1;
    end else begin
      presc <= presc + 22'h00_0001;
      tick  <= 1'b0;
    end
  end

  // command queue: commands wait here while the sequencer is busy
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q_wr <= 3'h0;
      for (int i = 0; i < CMDQ_DEPTH; i++) begin
        cmdq[i]  <= 3'h0;
        q_arg[i] <= 32'h0000_0000;
      end
    end else if (cmd_wr) begin
      cmdq[q_wr[1:0]]  <= pwdata[2:0];
      // full 32-bit hold length, latched as the command is queued
      q_arg[q_wr[1:0]] <= hold_len;
      q_wr             <= q_wr + 3'h1;
    end
  end

  // sequencer state machine
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state        <= ST_IDLE;
      hold_left    <= 32'h0000_0000;
      q_rd         <= 3'h0;
      scan_cont    <= 1'b0;
      meas_start   <= 1'b0;
      scan_advance <= 1'b0;
    end else begin
      meas_start   <= 1'b0;
      scan_advance <= 1'b0;
      if (dev_clear) begin
        state     <= ST_IDLE;
        hold_left <= 32'h0000_0000;
        q_rd      <= q_wr;
        scan_cont <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            if (step_ok) begin
              scan_advance <= 1'b1;
              state        <= ST_SCAN;
            end else if (!q_empty) begin
              q_rd <= q_rd + 3'h1;
              case (cur_cmd)
                CMD_HOLD: begin
                  hold_left <= (cur_arg > HOLD_MAX) ? HOLD_MAX
                                                    : cur_arg;
                  state     <= ST_HOLD;
                end
                CMD_SAMPLE: begin
                  hold_left <= sample_settle_time;
                  state     <= ST_SETTLE;
                end
                CMD_TRIG_WAIT: begin
                  state <= ST_TWAIT;
                end
                CMD_QUERY: begin
                  meas_start <= 1'b1;
                end
                CMD_SCAN_RUN: begin
                  // first point runs at the present parameter values
                  if (coupled) begin
                    scan_cont  <= 1'b1;
                    meas_start <= 1'b1;
                    state      <= ST_SCAN;
                  end
                end
                default: begin
                  state <= ST_IDLE;
                end
              endcase
            end
          end
          ST_HOLD, ST_SETTLE: begin
            // the queue is not served until the delay runs out
            if (hold_left == 32'h0000_0000) begin
              state <= ST_IDLE;
            end else if (tick) begin
              hold_left <= hold_left - 32'h0000_0001;
            end
          end
          ST_TWAIT: begin
            if (trig_take) begin
              state <= ST_IDLE;
            end
          end
          ST_SCAN: begin
            // a step stops a running scan; parameters are not reset
            if (step_key) begin
              scan_cont <= 1'b0;
            end
            if (scan_advance) begin
              meas_start <= 1'b1;
            end else if (meas_done) begin
              if (scan_cont && !step_key) begin
                scan_advance <= 1'b1;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // query tracking: a later query aborts an earlier pending one
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      query_pending <= 1'b0;
      query_abort   <= 1'b0;
    end else begin
      query_abort <= 1'b0;
      if (state == ST_IDLE && !q_empty && cur_cmd == CMD_QUERY &&
          !step_ok && !dev_clear) begin
        query_abort   <= query_pending;
        query_pending <= 1'b1;
      end else if (meas_done || dev_clear) begin
        query_pending <= 1'b0;
      end
    end
  end

  // scan iteration counter and step errors
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scan_iteration_count <= 16'h0000;
      err_no_couple        <= 1'b0;
      err_count_reached    <= 1'b0;
    end else begin
      err_no_couple     <= step_key && !coupled;
      err_count_reached <= step_key && coupled && cnt_hit;
      if (state == ST_IDLE && !q_empty && cur_cmd == CMD_CNT_RST &&
          !step_ok) begin
        scan_iteration_count <= 16'h0000;
      end else if (state == ST_SCAN && meas_done) begin
        scan_iteration_count <= scan_iteration_count + 16'h0001;
      end
    end
  end

  // trigger buffer and unexpected-trigger flag
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trig_cnt   <= 8'h00;
      unexp_trig <= 1'b0;
    end else begin
      if (policy_wr) begin
        trig_cnt <= 8'h00;
      end else if (buf_take && !trig_in) begin
        // a live pulse in the same cycle keeps the count as it is
        trig_cnt <= trig_cnt - 8'h01;
      end else if (trig_in && !trig_take && !trigger_policy &&
                   trig_cnt != TRIG_FULL) begin
        trig_cnt <= trig_cnt + 8'h01;
      end
      // set wins over the clear at result time
      if (trig_in && !trig_take && trigger_policy) begin
        unexp_trig <= 1'b1;
      end else if (meas_done || (policy_wr && !pwdata[CTRL_POLICY_BIT])) begin
        unexp_trig <= 1'b0;
      end
    end
  end

  // flag reported alongside the result
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      err_unexp_trig <= 1'b0;
    end else if (meas_done) begin
      err_unexp_trig <= unexp_trig ||
                        (trig_in && !trig_take && trigger_policy);
    end else if (meas_start) begin
      err_unexp_trig <= 1'b0;
    end
  end

  // display and serial front-end controls
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hold_indicator_text <= 1'b0;
      echo_enable         <= 1'b1;
      prompt_enable       <= 1'b1;
    end else begin
      hold_indicator_text <= (state == ST_HOLD || state == ST_TWAIT) &&
                             !macro_query;
      echo_enable         <= state == ST_IDLE;
      prompt_enable       <= state == ST_IDLE && q_empty;
    end
  end

  // configuration registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trigger_policy       <= POLICY_RST;
      coupled              <= 1'b0;
      macro_query          <= 1'b0;
      sample_settle_time   <= SETTLE_RST;
      hold_len             <= 32'h0000_0000;
      scan_iteration_limit <= 16'h0000;
    end else if (wr_acc) begin
      if (hit(paddr, CTRL_OFS)) begin
        trigger_policy <= pwdata[CTRL_POLICY_BIT];
        coupled        <= pwdata[CTRL_COUPLED_BIT];
        macro_query    <= pwdata[CTRL_MACROQ_BIT];
      end
      if (hit(paddr, HOLD_OFS)) begin
        hold_len <= pwdata;
      end
      if (hit(paddr, SETTLE_OFS)) begin
        sample_settle_time <= pwdata;
      end
      if (hit(paddr, SCAN_OFS)) begin
        scan_iteration_limit <= pwdata[15:0];
      end
    end
  end

  // apb read mux, zero wait state
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (paddr)
      CTRL_OFS:    next_rdata = {29'h0, macro_query, coupled,
                                 trigger_policy};
      HOLD_OFS:    next_rdata = hold_left;
      SETTLE_OFS:  next_rdata = sample_settle_time;
      STATUS_OFS:  next_rdata = {27'h0, unexp_trig, q_full, state};
      SCAN_OFS:    next_rdata = {scan_iteration_count,
                                 scan_iteration_limit};
      TRIGCNT_OFS: next_rdata = {24'h0, trig_cnt};
      default:     next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && paddr > TRIGCNT_OFS;
      if (rd_acc) begin
        prdata <= next_rdata;
      end
    end
  end
endmodule // wts_sequencer

// [wts_sequencer_properties.sv]
// checker: port-level properties of the sequencer
`timescale 1ns/100ps
module wts_seq_props (
  // clock and reset
  input logic       mclk,
  input logic       rst_n,
  // apb
  input logic       psel,
  input logic       penable,
  input logic [7:0] paddr,
  input logic       pready,
  input logic       pslverr,
  // step and engine
  input logic       step_key,
  input logic       meas_done,
  input logic       scan_advance,
  input logic       meas_start,
  input logic       err_no_couple,
  input logic       err_count_reached,
  // display and serial
  input logic       hold_indicator_text,
  input logic       echo_enable,
  input logic       prompt_enable
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("no apb answer");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  bad_addr_a: assert property (pready |-> pslverr == (paddr > 8'h18))
    else $error("pslverr wrong");
  step_adv_a: assert property (
    scan_advance |-> ($past(step_key) || $past(meas_done)) &&
                     !err_no_couple)
    else $error("advance without step");
  adv_meas_a: assert property (scan_advance |=> meas_start)
    else $error("no measure after advance");
  no_couple_a: assert property (
    err_no_couple |-> $past(step_key) && !scan_advance)
    else $error("stray coupling error");
  limit_err_a: assert property (
    err_count_reached |-> $past(step_key) && !scan_advance)
    else $error("stray limit error");
  hold_silent_a: assert property (
    hold_indicator_text |-> !echo_enable && !prompt_enable)
    else $error("echo during hold");
  cover property (scan_advance ##1 meas_start);
  cover property (err_count_reached);
  cover property (hold_indicator_text);
endmodule // wts_seq_props

bind wts_sequencer wts_seq_props u_props (
  .mclk, .rst_n, .psel, .penable, .paddr, .pready, .pslverr, .step_key,
  .meas_done,
  .scan_advance, .meas_start, .err_no_couple, .err_count_reached,
  .hold_indicator_text, .echo_enable, .prompt_enable
);

// [wts_engine_model.sv]
// measurement engine model: each run that is not restarted gives one done pulse
`timescale 1ns/100ps
module wts_engine_model (
  // clock and reset
  input  logic mclk,
  input  logic rst_n,
  // engine handshake
  input  logic meas_start,
  input  logic slow,
  output logic meas_done
);
  logic [5:0] cnt;
  // a new start restarts the run; an aborted run still reports only if restarted while cnt is 1
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt       <= 6'h00;
      meas_done <= 1'b0;
    end else begin
      meas_done <= (cnt == 6'h01);
      if (meas_start) begin
        cnt <= slow ? 6'h28 : 6'h03;
      end else if (cnt != 6'h00) begin
        cnt <= cnt - 6'h01;
      end
    end
  end
endmodule // wts_engine_model

// [testbench.sv]
// testbench: self-checking run of the wait, trigger and step sequencer
`timescale 1ns/100ps
module testbench
  import wts_pkg::*;
;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d, e;} wts_row_t;
  logic        mclk = 1'b0, rst_n = 1'b0, slow = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, held;
  logic        trig_in = 1'b0, step_key = 1'b0, dev_clear = 1'b0;
  logic        pready, pslverr, serr, meas_done, meas_start, scan_advance;
  logic        query_abort, hold_indicator_text, echo_enable, prompt_enable;
  logic        err_unexp_trig, err_no_couple, err_count_reached;
  int          n_fail = 0, comparisons = 0, n_abort = 0;
  wts_row_t    rows [5] = '{
    '{1'b0, SETTLE_OFS, 32'h0000_0000, SETTLE_RST},
    '{1'b0, TRIGCNT_OFS, 32'h0000_0000, 32'h0000_0000},
    '{1'b0, STATUS_OFS, 32'h0000_0000, 32'h0000_0000},
    '{1'b1, SCAN_OFS, 32'h0000_0002, 32'h0000_0000},
    '{1'b0, SCAN_OFS, 32'h0000_0000, 32'h0000_0002}};

  wts_sequencer uut (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .trig_in, .step_key, .dev_clear,
    .meas_done, .meas_start, .scan_advance, .query_abort,
    .hold_indicator_text, .echo_enable, .prompt_enable, .err_unexp_trig,
    .err_no_couple, .err_count_reached);
  wts_engine_model u_eng (.mclk, .rst_n, .meas_start, .slow, .meas_done);

  always #20 mclk = ~mclk;
  always @(posedge mclk) if (query_abort === 1'b1) n_abort++;

  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // answer taken at the rising edge that samples pready high
  task automatic apb(input logic w, input logic [7:0] a, input [31:0] d);
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd   = prdata;
    serr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic step(input logic [2:0] e);
    @(posedge mclk);
    step_key <= 1'b1;
    @(posedge mclk);
    step_key <= 1'b0;
    @(negedge mclk);
    chk("step out", e, {scan_advance, err_no_couple, err_count_reached});
    repeat (12) @(posedge mclk);
  endtask

  task automatic end_sim;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #1_600_000;
    n_fail++;
    end_sim();
  end

  initial begin
    repeat (20) @(posedge mclk);
    chk("echo", 1'h1, echo_enable && prompt_enable);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk("table", rows[i].e, rd);
    end
    apb(1'b0, 8'h1c, 32'h0000_0000);
    chk("slverr", 1'h1, serr);
    repeat (514) @(posedge mclk) trig_in <= ~trig_in;
    apb(1'b0, TRIGCNT_OFS, 32'h0000_0000);
    chk("trig full", {24'h00_0000, TRIG_FULL}, rd);
    apb(1'b1, CTRL_OFS, 32'h0000_0000);
    apb(1'b0, TRIGCNT_OFS, 32'h0000_0000);
    chk("trig clear", 32'h0000_0000, rd);
    step(3'h2);
    apb(1'b1, CTRL_OFS, 32'h0000_0002);
    step(3'h4);
    step(3'h4);
    step(3'h1);
    apb(1'b0, SCAN_OFS, 32'h0000_0000);
    chk("scan count", 32'h0002_0002, rd);
    chk("no flag", 1'h0, err_unexp_trig);
    apb(1'b1, CTRL_OFS, 32'h0000_0003);
    repeat (2) @(posedge mclk) trig_in <= ~trig_in;
    apb(1'b1, CMD_OFS, {29'h0000_0000, CMD_CNT_RST});
    chk("flag early", 1'h0, err_unexp_trig);
    step(3'h4);
    chk("flag", 1'h1, err_unexp_trig);
    slow <= 1'b1;
    apb(1'b1, CMD_OFS, {29'h0000_0000, CMD_QUERY});
    apb(1'b1, CMD_OFS, {29'h0000_0000, CMD_QUERY});
    repeat (60) @(posedge mclk);
    chk("abort", 1'h1, n_abort > 0);
    slow <= 1'b0;
    apb(1'b1, CMD_OFS, {29'h0000_0000, CMD_SAMPLE});
    repeat (5) @(posedge mclk);
    apb(1'b0, STATUS_OFS, 32'h0000_0000);
    chk("settle 0", 32'h0000_0000, {29'h0000_0000, rd[2:0]});
    apb(1'b1, HOLD_OFS, 32'hffff_ffff);
    apb(1'b1, CMD_OFS, {29'h0000_0000, CMD_HOLD});
    apb(1'b0, HOLD_OFS, 32'h0000_0000);
    chk("hold left", HOLD_MAX, rd);
    chk("hold text", 1'h1, hold_indicator_text);
    apb(1'b1, CMD_OFS, {29'h0000_0000, CMD_SAMPLE});
    step(3'h0);
    apb(1'b0, STATUS_OFS, 32'h0000_0000);
    chk("hold on", 32'h0000_0001, {29'h0000_0000, rd[2:0]});
    @(posedge mclk) dev_clear <= 1'b1;
    @(posedge mclk) dev_clear <= 1'b0;
    repeat (6) @(posedge mclk);
    apb(1'b0, STATUS_OFS, 32'h0000_0000);
    chk("cleared", 32'h0000_0000, {29'h0000_0000, rd[2:0]});
    chk("echo back", 1'h1, echo_enable);
    apb(1'b1, CTRL_OFS, 32'h0000_0002);
    @(posedge mclk) trig_in <= 1'b1;
    @(posedge mclk) trig_in <= 1'b0;
    apb(1'b1, CMD_OFS, {29'h0000_0000, CMD_TRIG_WAIT});
    repeat (3) @(posedge mclk);
    apb(1'b0, TRIGCNT_OFS, 32'h0000_0000);
    chk("trig used", 32'h0000_0000, rd);
    apb(1'b0, STATUS_OFS, 32'h0000_0000);
    chk("wait met", 32'h0000_0000, {29'h0000_0000, rd[2:0]});
    apb(1'b1, CTRL_OFS, 32'h0000_0006);
    apb(1'b1, CMD_OFS, {29'h0000_0000, CMD_TRIG_WAIT});
    repeat (3) @(posedge mclk);
    apb(1'b0, STATUS_OFS, 32'h0000_0000);
    chk("trig stall", 32'h0000_0003, {29'h0000_0000, rd[2:0]});
    chk("macro text", 1'h0, hold_indicator_text);
    @(posedge mclk) trig_in <= 1'b1;
    @(posedge mclk) trig_in <= 1'b0;
    repeat (2) @(posedge mclk);
    apb(1'b0, STATUS_OFS, 32'h0000_0000);
    chk("trig go", 32'h0000_0000, {29'h0000_0000, rd[2:0]});
    apb(1'b1, SCAN_OFS, 32'h0000_0000);
    apb(1'b1, CMD_OFS, {29'h0000_0000, CMD_SCAN_RUN});
    repeat (20) @(posedge mclk);
    apb(1'b0, STATUS_OFS, 32'h0000_0000);
    chk("scanning", 32'h0000_0004, {29'h0000_0000, rd[2:0]});
    @(posedge mclk) step_key <= 1'b1;
    @(posedge mclk) step_key <= 1'b0;
    repeat (20) @(posedge mclk);
    apb(1'b0, SCAN_OFS, 32'h0000_0000);
    held = rd;
    repeat (20) @(posedge mclk);
    apb(1'b0, STATUS_OFS, 32'h0000_0000);
    chk("scan stop", 32'h0000_0000, {29'h0000_0000, rd[2:0]});
    apb(1'b0, SCAN_OFS, 32'h0000_0000);
    chk("scan kept", held, rd);
    chk("scan ran", 1'h1, held[31:16] > 16'h0001);
    end_sim();
  end
endmodule // testbench
